// file: rams_consts.svh
// Purpose: shared offsets, field positions, reset values and timing counts
// Assumes: included by its bare name
// Notes: definitions only
`ifndef RAMS_CONSTS_SVH
`define RAMS_CONSTS_SVH

// register offsets on the serial control port
`define RAMS_ADDR_RX_WIN 6'h01
`define RAMS_ADDR_TX_WIN 6'h02
`define RAMS_ADDR_TX_LEN 6'h03
`define RAMS_ADDR_SEQ 6'h06
`define RAMS_ADDR_STATUS 6'h24
`define RAMS_ADDR_RX_INFO 6'h2D

// sequence_control fields
`define RAMS_SEQ_TRIG_BIT 7
`define RAMS_SEQ_RX_MASK_BIT 8
`define RAMS_SEQ_TX_MASK_BIT 9
`define RAMS_SEQ_WR_MASK 16'h1B83
`define RAMS_SEQ_RESET 16'h0000

// transmit_length_control fields
`define RAMS_TXLEN_WR_MASK 16'h007F
`define RAMS_TXLEN_RESET 16'h0000

// interrupt_flags fields
`define RAMS_ST_CRC_BIT 0
`define RAMS_ST_TX_BIT 6
`define RAMS_ST_RX_BIT 7

// serial header: bit 7 high marks a read
`define RAMS_SPI_READ_BIT 7

// frame check polynomial, reflected form
`define RAMS_CRC_POLY 16'h8408

// link quality window
`define RAMS_LQI_WINDOW_NS 64000
`define RAMS_SYS_PERIOD_NS 25
`define RAMS_LQI_CYCLES ((`RAMS_LQI_WINDOW_NS + `RAMS_SYS_PERIOD_NS - 1) / `RAMS_SYS_PERIOD_NS)

`endif

// file: rams_host_model.sv
// Purpose: host model for the serial port and go pin
// Assumes: serial clock 160 ns, low and still between frames
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ps
module rams_host_model (
	output logic spiClk,
	output logic spiCsB,
	output logic spiMosi,
	output logic radioGoEnable,
	input wire logic spiMiso
);
	initial begin
		spiClk = 1'b0;
		spiCsB = 1'b1;
		spiMosi = 1'b0;
		radioGoEnable = 1'b0;
	end
	task automatic go(input logic v);
		radioGoEnable = v;
	endtask
	// header, pad on reads, then n words, msb first
	task automatic frame(input logic [7:0] hdr, input int n, input logic [15:0] wd[4],
			output logic [15:0] rd[4]);
		int nb;
		int p;
		nb = hdr[7] ? 16 : 8;
		rd = '{default: 16'h0000};
		#3;
		spiCsB = 1'b0;
		for (int i = 0; i < nb + 16 * n; i++) begin
			p = i - nb;
			spiMosi = (i < 8) ? hdr[7 - i] : (p < 0) ? 1'b0 : wd[p / 16][15 - p % 16];
			#80;
			spiClk = 1'b1;
			if (p >= 0)
				rd[p / 16][15 - p % 16] = spiMiso;
			#80;
			spiClk = 1'b0;
		end
		#80;
		spiCsB = 1'b1;
		spiMosi = ~spiMosi;
		#240;
	endtask
endmodule

// file: rams_pkg.sv
// Purpose: types of the active mode sequencer
// Assumes: nothing
// Notes: codes written out
package rams_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_CCA = 2'h1,
		SEQ_RX = 2'h2,
		SEQ_TX = 2'h3
	} rams_seq_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CCA = 3'h1,
		ST_RX_WAIT = 3'h2,
		ST_RX_LEN = 3'h3,
		ST_RX_DATA = 3'h4,
		ST_TX_SEND = 3'h5,
		ST_TX_END = 3'h6
	} rams_state_type;

	typedef enum logic [1:0] {
		PH_HEAD = 2'h0,
		PH_PAD = 2'h1,
		PH_DATA = 2'h2
	} rams_phase_type;
endpackage

// file: rams_sequencer.sv
// Purpose: active mode sequencer of a 2.4 GHz radio modem with its serial control port
// Assumes: modem strobes are on clk_sys; spiClk only runs while spiCsB is low
// Notes: packet mode only
`timescale 1ns/1ps
`include "rams_consts.svh"

module rams_sequencer #(
	parameter int RAM_WORDS = 64,
	parameter int CLKOUT_DIV = 2
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic spiClk,
	input wire logic spiCsB,
	input wire logic spiMosi,
	output logic spiMiso,
	input wire logic radioGoEnable,
	input wire logic timerMatch,
	input wire logic clkOutEnable,
	output logic clkOut,
	input wire logic preambleSeen,
	input wire logic sfdSeen,
	input wire logic rxByteValid,
	input wire logic [7:0] rxByte,
	input wire logic [7:0] energyLevel,
	input wire logic ccaDone,
	input wire logic txByteTake,
	input wire logic txFrameEnd,
	output logic [7:0] txByte,
	output logic txByteValid,
	output logic rxPowerOn,
	output logic txPowerOn,
	output logic irqB
);
	localparam int RAM_AW = $clog2(RAM_WORDS);
	localparam int LQI_CYCLES = `RAMS_LQI_CYCLES;
	localparam logic [11:0] LQI_LAST = 12'(LQI_CYCLES - 1);
	localparam logic [7:0] CLK_LAST = 8'(CLKOUT_DIV - 1);
	localparam logic [RAM_AW-1:0] PTR_ONE = RAM_AW'(1);

	if (RAM_WORDS < 64 || CLKOUT_DIV < 1 || CLKOUT_DIV > 256 || LQI_CYCLES > 4096) begin : g_chk
		$error("rams_sequencer: unsupported parameter value");
	end

	function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c;
		for (int i = 0; i < 8; i++) begin
			if (x[0] ^ d[i]) begin
				x = (x >> 1) ^ `RAMS_CRC_POLY;
			end else begin
				x = x >> 1;
			end
		end
		return x;
	endfunction

	logic [15:0] rxRam [RAM_WORDS];
	logic [15:0] txRam [RAM_WORDS];

	// link side: serial shifter on spiClk, reset while deselected
	wire spiRstB = rst_b & ~spiCsB;
	rams_pkg::rams_phase_type phase;
	logic [3:0] bitCnt;
	logic [14:0] shiftIn;
	logic [5:0] addrReg;
	logic readReg, firstWord, loadTgl, loadSeen;
	logic reqTgl, reqWrite, reqFirst;
	logic [5:0] reqAddr;
	logic [15:0] reqData, holdData, outShift, respData;
	logic ackTgl, ackSync1, ackSync2, ackSeen;
	logic misoReg;

	wire headDone = (phase == rams_pkg::PH_HEAD) && (bitCnt == 4'h7);
	wire padDone = (phase == rams_pkg::PH_PAD) && (bitCnt == 4'h7);
	wire wordDone = (phase == rams_pkg::PH_DATA) && (bitCnt == 4'hF);
	wire [7:0] hdrByte = {shiftIn[6:0], spiMosi};
	wire [15:0] wordIn = {shiftIn, spiMosi};
	wire issueWrite = wordDone && !readReg;
	// next receive word fetched as the current one loads, so it is ready at word end
	wire issueRead = (headDone && hdrByte[`RAMS_SPI_READ_BIT]) ||
		((padDone || wordDone) && readReg && addrReg == `RAMS_ADDR_RX_WIN);

	always_ff @(posedge spiClk or negedge spiRstB) begin
		if (!spiRstB) begin
			phase <= rams_pkg::PH_HEAD;
			bitCnt <= 4'h0;
			shiftIn <= 15'h0000;
			addrReg <= 6'h00;
			readReg <= 1'b0;
			firstWord <= 1'b1;
			loadTgl <= 1'b0;
		end else begin
			shiftIn <= wordIn[14:0];
			bitCnt <= bitCnt + 4'h1;
			if (headDone) begin
				addrReg <= hdrByte[5:0];
				readReg <= hdrByte[`RAMS_SPI_READ_BIT];
				phase <= hdrByte[`RAMS_SPI_READ_BIT] ? rams_pkg::PH_PAD : rams_pkg::PH_DATA;
				bitCnt <= 4'h0;
			end else if (padDone) begin
				phase <= rams_pkg::PH_DATA;
				bitCnt <= 4'h0;
				loadTgl <= ~loadTgl;
			end else if (wordDone) begin
				firstWord <= 1'b0;
				if (readReg) begin
					loadTgl <= ~loadTgl;
				end
			end
		end
	end

	// request words held stable while the toggle crosses
	always_ff @(posedge spiClk or negedge rst_b) begin
		if (!rst_b) begin
			reqTgl <= 1'b0;
			reqAddr <= 6'h00;
			reqWrite <= 1'b0;
			reqFirst <= 1'b0;
			reqData <= 16'h0000;
		end else if (issueRead || issueWrite) begin
			reqTgl <= ~reqTgl;
			reqAddr <= headDone ? hdrByte[5:0] : addrReg;
			reqWrite <= issueWrite;
			reqFirst <= headDone || (issueWrite && firstWord);
			reqData <= wordIn;
		end
	end

	always_ff @(posedge spiClk or negedge rst_b) begin
		if (!rst_b) begin
			ackSync1 <= 1'b0;
			ackSync2 <= 1'b0;
			ackSeen <= 1'b0;
			holdData <= 16'h0000;
		end else begin
			ackSync1 <= ackTgl;
			ackSync2 <= ackSync1;
			ackSeen <= ackSync2;
			if (ackSync2 ^ ackSeen) begin
				holdData <= respData;
			end
		end
	end

	// read data leaves on the falling edge
	always_ff @(negedge spiClk or negedge spiRstB) begin
		if (!spiRstB) begin
			loadSeen <= 1'b0;
			outShift <= 16'h0000;
			misoReg <= 1'b0;
		end else begin
			loadSeen <= loadTgl;
			if (loadTgl ^ loadSeen) begin
				misoReg <= holdData[15];
				outShift <= {holdData[14:0], 1'b0};
			end else begin
				misoReg <= outShift[15];
				outShift <= {outShift[14:0], 1'b0};
			end
		end
	end
	assign spiMiso = misoReg;

	// system side: register access
	logic reqSync1, reqSync2, reqSeen;
	logic goSync1, goSync2, ckSync1, ckSync2;
	logic [15:0] seqReg, txLenReg, readValue;
	logic [RAM_AW-1:0] rxRdPtr, txWrPtr;
	logic rxDoneFlag, txDoneFlag, crcOkFlag, irqBReg;
	logic [6:0] rxLenField;
	logic [7:0] lqiField;

	wire reqEvent = reqSync2 ^ reqSeen;
	wire seqWrite = reqEvent && reqWrite && reqAddr == `RAMS_ADDR_SEQ;
	wire txWinWrite = reqEvent && reqWrite && reqAddr == `RAMS_ADDR_TX_WIN;
	wire rxWinRead = reqEvent && !reqWrite && reqAddr == `RAMS_ADDR_RX_WIN;
	wire statusRead = reqEvent && !reqWrite && reqAddr == `RAMS_ADDR_STATUS;
	wire [RAM_AW-1:0] rxRdIdx = reqFirst ? '0 : rxRdPtr;
	wire [RAM_AW-1:0] txWrIdx = reqFirst ? '0 : txWrPtr;
	wire rams_pkg::rams_seq_type seqField = rams_pkg::rams_seq_type'(seqReg[1:0]);

	always_comb begin
		if (reqAddr == `RAMS_ADDR_RX_WIN) begin
			readValue = rxRam[rxRdIdx];
		end else if (reqAddr == `RAMS_ADDR_TX_LEN) begin
			readValue = txLenReg;
		end else if (reqAddr == `RAMS_ADDR_SEQ) begin
			readValue = seqReg;
		end else if (reqAddr == `RAMS_ADDR_STATUS) begin
			readValue = 16'h0000;
			readValue[`RAMS_ST_RX_BIT] = rxDoneFlag;
			readValue[`RAMS_ST_TX_BIT] = txDoneFlag;
			readValue[`RAMS_ST_CRC_BIT] = crcOkFlag;
		end else if (reqAddr == `RAMS_ADDR_RX_INFO) begin
			readValue = {lqiField, 1'b0, rxLenField};
		end else begin
			readValue = 16'h0000;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reqSync1 <= 1'b0;
			reqSync2 <= 1'b0;
			reqSeen <= 1'b0;
			ackTgl <= 1'b0;
			respData <= 16'h0000;
			rxRdPtr <= '0;
			txWrPtr <= '0;
		end else begin
			reqSync1 <= reqTgl;
			reqSync2 <= reqSync1;
			reqSeen <= reqSync2;
			if (reqEvent) begin
				ackTgl <= ~ackTgl;
				if (!reqWrite) begin
					respData <= readValue;
				end
			end
			if (rxWinRead) begin
				rxRdPtr <= rxRdIdx + PTR_ONE;
			end
			if (txWinWrite) begin
				txWrPtr <= txWrIdx + PTR_ONE;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (txWinWrite) begin
			txRam[txWrIdx] <= reqData;
		end
	end

	// only the host changes the field
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			seqReg <= `RAMS_SEQ_RESET;
			txLenReg <= `RAMS_TXLEN_RESET;
		end else if (reqEvent && reqWrite) begin
			if (reqAddr == `RAMS_ADDR_SEQ) begin
				seqReg <= reqData & `RAMS_SEQ_WR_MASK;
			end else if (reqAddr == `RAMS_ADDR_TX_LEN) begin
				txLenReg <= reqData & `RAMS_TXLEN_WR_MASK;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			goSync1 <= 1'b0;
			goSync2 <= 1'b0;
			ckSync1 <= 1'b0;
			ckSync2 <= 1'b0;
		end else begin
			goSync1 <= radioGoEnable;
			goSync2 <= goSync1;
			ckSync1 <= clkOutEnable;
			ckSync2 <= ckSync1;
		end
	end

	// sequencer
	rams_pkg::rams_state_type state;
	logic armed, preambleGot, txValidReg;
	logic [7:0] byteIdx, lowByte, txByteReg;
	logic [15:0] crcReg;
	logic [6:0] lenByte;

	wire rxActive = state == rams_pkg::ST_RX_WAIT || state == rams_pkg::ST_RX_LEN ||
		state == rams_pkg::ST_RX_DATA;
	wire rxDataByte = state == rams_pkg::ST_RX_DATA && rxByteValid;
	wire rxLast = byteIdx == {1'b0, lenByte} - 8'h01;
	wire [15:0] crcNextRx = crcByte(crcReg, rxByte);
	// abort by go pin low or code zero
	wire rxAbort = rxActive && (!goSync2 || (seqWrite && reqData[1:0] == 2'h0));
	wire rxFinish = !rxAbort && ((state == rams_pkg::ST_RX_LEN && rxByteValid &&
		rxByte[6:0] == 7'h00) || (rxDataByte && rxLast));
	// go pin and timer gate the start
	// timer trigger waits for the match
	wire startOk = state == rams_pkg::ST_IDLE && armed && goSync2 &&
		(!seqReg[`RAMS_SEQ_TRIG_BIT] || timerMatch);
	// length includes the two check bytes
	wire [7:0] txLen = {1'b0, txLenReg[6:0]};
	wire txTake = state == rams_pkg::ST_TX_SEND && txByteTake && txValidReg;
	wire txIsData = byteIdx >= 8'h01 && byteIdx + 8'h02 <= txLen;
	wire [15:0] crcTxUpd = txIsData ? crcByte(crcReg, txByteReg) : crcReg;
	wire [7:0] txNxt = byteIdx + 8'h01;
	wire [15:0] txWord = txRam[RAM_AW'(byteIdx[7:1])];
	logic [7:0] txNextByte;

	always_comb begin
		if (txNxt + 8'h02 <= txLen) begin
			txNextByte = byteIdx[0] ? txWord[15:8] : txWord[7:0];
		end else if (txNxt + 8'h01 == txLen) begin
			txNextByte = crcTxUpd[7:0];
		end else begin
			txNextByte = crcTxUpd[15:8];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			armed <= 1'b0;
		end else if (seqWrite) begin
			armed <= reqData[1:0] != 2'h0;
		end else if (startOk) begin
			armed <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= rams_pkg::ST_IDLE;
			preambleGot <= 1'b0;
			byteIdx <= 8'h00;
			lowByte <= 8'h00;
			crcReg <= 16'h0000;
			lenByte <= 7'h00;
			txByteReg <= 8'h00;
			txValidReg <= 1'b0;
		end else begin
			case (state)
				rams_pkg::ST_IDLE: begin
					// channel check only from its code
					if (startOk) begin
						case (seqField)
							rams_pkg::SEQ_CCA: state <= rams_pkg::ST_CCA;
							rams_pkg::SEQ_RX: begin
								state <= rams_pkg::ST_RX_WAIT;
								preambleGot <= 1'b0;
							end
							rams_pkg::SEQ_TX: begin
								state <= rams_pkg::ST_TX_SEND;
								byteIdx <= 8'h00;
								crcReg <= 16'h0000;
								txByteReg <= txLen;
								txValidReg <= 1'b1;
							end
							default: state <= rams_pkg::ST_IDLE;
						endcase
					end
				end
				rams_pkg::ST_CCA: begin
					if (ccaDone) begin
						state <= rams_pkg::ST_IDLE;
					end
				end
				rams_pkg::ST_RX_WAIT: begin
					if (preambleSeen) begin
						preambleGot <= 1'b1;
					end
					if (sfdSeen && (preambleGot || preambleSeen)) begin
						state <= rams_pkg::ST_RX_LEN;
					end
				end
				rams_pkg::ST_RX_LEN: begin
					if (rxByteValid) begin
						lenByte <= rxByte[6:0];
						byteIdx <= 8'h00;
						crcReg <= 16'h0000;
						state <= (rxByte[6:0] == 7'h00) ? rams_pkg::ST_IDLE : rams_pkg::ST_RX_DATA;
					end
				end
				rams_pkg::ST_RX_DATA: begin
					if (rxByteValid) begin
						crcReg <= crcNextRx;
						byteIdx <= byteIdx + 8'h01;
						lowByte <= rxByte;
						if (rxLast) begin
							state <= rams_pkg::ST_IDLE;
						end
					end
				end
				rams_pkg::ST_TX_SEND: begin
					if (txTake) begin
						crcReg <= crcTxUpd;
						byteIdx <= txNxt;
						if (byteIdx >= txLen) begin
							txValidReg <= 1'b0;
							state <= rams_pkg::ST_TX_END;
						end else begin
							txByteReg <= txNextByte;
						end
					end
				end
				rams_pkg::ST_TX_END: begin
					if (txFrameEnd) begin
						state <= rams_pkg::ST_IDLE;
					end
				end
				default: state <= rams_pkg::ST_IDLE;
			endcase
			if (rxAbort) begin
				state <= rams_pkg::ST_IDLE;
			end
		end
	end

	// payload bytes packed low byte first
	always_ff @(posedge clk_sys) begin
		if (rxDataByte && (byteIdx[0] || rxLast)) begin
			rxRam[RAM_AW'(byteIdx[7:1])] <= byteIdx[0] ? {rxByte, lowByte} : {8'h00, rxByte};
		end
	end

	wire txFinish = state == rams_pkg::ST_TX_END && txFrameEnd;
	wire crcGood = state == rams_pkg::ST_RX_DATA && crcNextRx == 16'h0000;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rxDoneFlag <= 1'b0;
			txDoneFlag <= 1'b0;
			crcOkFlag <= 1'b0;
			rxLenField <= 7'h00;
			irqBReg <= 1'b1;
		end else begin
			// receive done, set wins over clear
			// transmit done, set wins over clear
			rxDoneFlag <= rxFinish | (rxDoneFlag & ~statusRead);
			txDoneFlag <= txFinish | (txDoneFlag & ~statusRead);
			irqBReg <= ~((rxDoneFlag & seqReg[`RAMS_SEQ_RX_MASK_BIT]) |
				(txDoneFlag & seqReg[`RAMS_SEQ_TX_MASK_BIT]));
			if (rxFinish) begin
				crcOkFlag <= crcGood;
				rxLenField <= (state == rams_pkg::ST_RX_LEN) ? rxByte[6:0] : lenByte;
			end
		end
	end

	// peak energy over the window after preamble
	logic lqiRun;
	logic [11:0] lqiCnt;
	logic [7:0] lqiPeak;
	wire [7:0] lqiMax = (energyLevel > lqiPeak) ? energyLevel : lqiPeak;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lqiRun <= 1'b0;
			lqiCnt <= 12'h000;
			lqiPeak <= 8'h00;
			lqiField <= 8'h00;
		end else if (!lqiRun) begin
			if (state == rams_pkg::ST_RX_WAIT && preambleSeen) begin
				lqiRun <= 1'b1;
				lqiCnt <= 12'h000;
				lqiPeak <= energyLevel;
			end
		end else begin
			lqiPeak <= lqiMax;
			lqiCnt <= lqiCnt + 12'h001;
			if (lqiCnt == LQI_LAST) begin
				lqiRun <= 1'b0;
				lqiField <= lqiMax;
			end
		end
	end

	logic rxPowerReg, txPowerReg, clkOutReg;
	logic [7:0] clkCnt;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rxPowerReg <= 1'b0;
			txPowerReg <= 1'b0;
		end else begin
			rxPowerReg <= rxActive || state == rams_pkg::ST_CCA;
			txPowerReg <= state == rams_pkg::ST_TX_SEND || state == rams_pkg::ST_TX_END;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clkCnt <= 8'h00;
			clkOutReg <= 1'b0;
		end else if (!ckSync2) begin
			clkCnt <= 8'h00;
			clkOutReg <= 1'b0;
		end else if (clkCnt == CLK_LAST) begin
			clkCnt <= 8'h00;
			clkOutReg <= ~clkOutReg;
		end else begin
			clkCnt <= clkCnt + 8'h01;
		end
	end

	assign clkOut = clkOutReg;
	assign rxPowerOn = rxPowerReg;
	assign txPowerOn = txPowerReg;
	assign txByte = txByteReg;
	assign txByteValid = txValidReg;
	assign irqB = irqBReg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_idle_power_off: assert property ((state == rams_pkg::ST_IDLE) [*2] |-> !rxPowerOn && !txPowerOn)
		else $error("radio powered in idle");
	a_go_gates_exit: assert property ($past(state) == rams_pkg::ST_IDLE && state != rams_pkg::ST_IDLE |-> $past(goSync2))
		else $error("left idle with go pin low");
	a_timer_gates_exit: assert property ($past(state) == rams_pkg::ST_IDLE && state != rams_pkg::ST_IDLE && $past(seqReg[`RAMS_SEQ_TRIG_BIT]) |-> $past(timerMatch))
		else $error("timed start without match");
	a_cca_from_code: assert property ($past(state) == rams_pkg::ST_IDLE && state == rams_pkg::ST_CCA |-> $past(seqReg[1:0]) == 2'h1)
		else $error("channel check without its code");
	a_field_kept: assert property ($past(state) != rams_pkg::ST_IDLE && state == rams_pkg::ST_IDLE && !$past(seqWrite) |-> $stable(seqReg))
		else $error("sequence field changed at completion");
	a_tx_returns_idle: assert property (txFinish |=> state == rams_pkg::ST_IDLE ##1 txDoneFlag || statusRead)
		else $error("transmit did not end in idle");
	a_rx_done_irq: assert property (rxFinish && seqReg[`RAMS_SEQ_RX_MASK_BIT] && !statusRead |=> ##1 !irqB)
		else $error("receive done raised no interrupt");
	a_abort_quiet: assert property (rxAbort && !statusRead |=> rxDoneFlag == $past(rxDoneFlag) && crcOkFlag == $past(crcOkFlag))
		else $error("abort changed status");
	a_read_clears: assert property (statusRead && !rxFinish && !txFinish |=> !rxDoneFlag && !txDoneFlag ##1 irqB)
		else $error("status read did not clear");
	a_len_latched: assert property (rxFinish && state == rams_pkg::ST_RX_DATA |=> rxLenField == $past(lenByte) && crcOkFlag == ($past(crcNextRx) == 16'h0000))
		else $error("length or check flag wrong");
	a_lqi_window: assert property ($rose(lqiRun) |-> lqiRun [*8] ##1 (lqiCnt == 12'h008))
		else $error("quality window stopped early");

	c_rx_done: cover property (rxFinish && crcGood);
	c_tx_done: cover property (txFinish);
	c_rx_abort: cover property (rxAbort);
	c_cca_done: cover property (state == rams_pkg::ST_CCA && ccaDone);
endmodule

// file: tb.sv
// Purpose: self-checking bench of the active mode sequencer
// Assumes: host model drives the serial port, bench plays the modem
// Notes: seed 39, expectations from bench functions
`timescale 1ns/1ps
`include "rams_consts.svh"
module tb;
	logic clk_sys, rst_b = 1'b0, spiClk, spiCsB, spiMosi, spiMiso, radioGoEnable, clkOut;
	logic timerMatch, clkOutEnable, preambleSeen, sfdSeen;
	logic rxByteValid, ccaDone, txByteTake, txFrameEnd;
	logic [7:0] rxByte, energyLevel, txByte, e;
	logic txByteValid, rxPowerOn, txPowerOn, irqB, o;
	int failures = 0, n_tests = 0, seed = 39, cnt;
	logic [15:0] wd[4], rd[4], c;
	logic [7:0] b[6];
	rams_sequencer #(.RAM_WORDS(64), .CLKOUT_DIV(2)) i_rams_sequencer (.clk_sys(clk_sys),
		.rst_b(rst_b), .spiClk(spiClk), .spiCsB(spiCsB), .spiMosi(spiMosi), .spiMiso(spiMiso),
		.radioGoEnable(radioGoEnable), .timerMatch(timerMatch), .clkOutEnable(clkOutEnable),
		.clkOut(clkOut), .preambleSeen(preambleSeen), .sfdSeen(sfdSeen),
		.rxByteValid(rxByteValid), .rxByte(rxByte), .energyLevel(energyLevel),
		.ccaDone(ccaDone), .txByteTake(txByteTake), .txFrameEnd(txFrameEnd), .txByte(txByte),
		.txByteValid(txByteValid), .rxPowerOn(rxPowerOn), .txPowerOn(txPowerOn), .irqB(irqB));
	rams_host_model i_rams_host_model (.spiClk(spiClk), .spiCsB(spiCsB), .spiMosi(spiMosi),
		.radioGoEnable(radioGoEnable), .spiMiso(spiMiso));
	function automatic logic [15:0] crc(input logic [7:0] q[6]);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 1; i <= 3; i++)
			for (int k = 0; k < 8; k++)
				r = (r[0] ^ q[i][k]) ? ((r >> 1) ^ `RAMS_CRC_POLY) : (r >> 1);
		return r;
	endfunction
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		n_tests++;
		if (got !== ex) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] v);
		wd[0] = v;
		i_rams_host_model.frame({2'b00, a}, 1, wd, rd);
	endtask
	task automatic rdw(input logic [5:0] a, input int n);
		i_rams_host_model.frame({2'b10, a}, n, wd, rd);
	endtask
	task automatic wait_irq();
		for (int k = 0; k < 20 && irqB !== 1'b0; k++)
			cyc(1);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#2_000_000;
		failures++;
		print_verdict();
	end
	initial begin
		timerMatch <= 1'b0;
		clkOutEnable <= 1'b1;
		preambleSeen <= 1'b0;
		sfdSeen <= 1'b0;
		rxByteValid <= 1'b0;
		ccaDone <= 1'b0;
		txByteTake <= 1'b0;
		txFrameEnd <= 1'b0;
		rxByte <= 8'h00;
		energyLevel <= 8'h00;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		cyc(2);
		chk("power", 16'h0000, {14'h0000, rxPowerOn, txPowerOn});
		rdw(`RAMS_ADDR_SEQ, 1);
		chk("seq reset", `RAMS_SEQ_RESET, rd[0]);
		c = 16'($random(seed)) & 16'h0383;
		wr(`RAMS_ADDR_SEQ, c);
		rdw(`RAMS_ADDR_SEQ, 1);
		chk("seq back", c, rd[0]);
		wr(6'h3F, 16'hFFFF);
		rdw(6'h3F, 1);
		chk("unmapped", 16'h0000, rd[0]);
		cnt = 0;
		for (int k = 0; k < 8; k++) begin
			o = clkOut;
			cyc(1);
			cnt += int'(clkOut !== o);
		end
		chk("clkOut", 16'h0004, 16'(cnt));
		clkOutEnable <= 1'b0;
		cyc(4);
		chk("clkOut off", 16'h0000, {15'h0000, clkOut});
		clkOutEnable <= 1'b1;
		$display("test idle done");
		for (int t = 0; t < 2; t++) begin
			wr(`RAMS_ADDR_SEQ, t ? 16'h0081 : 16'h0001);
			cyc(10);
			chk("go held", 16'h0000, {15'h0000, rxPowerOn});
			i_rams_host_model.go(1'b1);
			cyc(8);
			chk("trig wait", 16'(t == 0), {15'h0000, rxPowerOn});
			@(posedge clk_sys);
			timerMatch <= 1'(t);
			@(posedge clk_sys);
			timerMatch <= 1'b0;
			cyc(4);
			chk("cca on", 16'h0001, {15'h0000, rxPowerOn});
			@(posedge clk_sys);
			ccaDone <= 1'b1;
			@(posedge clk_sys);
			ccaDone <= 1'b0;
			cyc(4);
			chk("cca off", 16'h0000, {15'h0000, rxPowerOn});
			i_rams_host_model.go(1'b0);
			rdw(`RAMS_ADDR_SEQ, 1);
			chk("seq kept", t ? 16'h0081 : 16'h0001, rd[0]);
		end
		$display("test cca done");
		for (int i = 1; i <= 3; i++)
			b[i] = 8'($random(seed));
		c = crc(b);
		b[0] = 8'h05;
		b[4] = c[7:0];
		b[5] = c[15:8];
		wr(`RAMS_ADDR_TX_LEN, 16'h0005);
		wd[0] = {b[2], b[1]};
		wd[1] = {8'h00, b[3]};
		i_rams_host_model.frame({2'b00, `RAMS_ADDR_TX_WIN}, 2, wd, rd);
		wr(`RAMS_ADDR_SEQ, 16'h0203);
		i_rams_host_model.go(1'b1);
		for (int i = 0; i < 6; i++) begin
			for (int k = 0; k < 50 && {txByteValid, txPowerOn} !== 2'b11; k++)
				cyc(1);
			chk("txByte", {8'h80, b[i]}, {txPowerOn, 7'h00, txByte});
			@(posedge clk_sys);
			txByteTake <= 1'b1;
			@(posedge clk_sys);
			txByteTake <= 1'b0;
			cyc(1);
		end
		chk("tx valid", 16'h0000, {15'h0000, txByteValid});
		@(posedge clk_sys);
		txFrameEnd <= 1'b1;
		@(posedge clk_sys);
		txFrameEnd <= 1'b0;
		wait_irq();
		chk("tx irq", 16'h0000, {14'h0000, txPowerOn, irqB});
		rdw(`RAMS_ADDR_STATUS, 1);
		chk("tx flag", 16'h0040, rd[0] & 16'h00C0);
		chk("irq clr", 16'h0001, {15'h0000, irqB});
		i_rams_host_model.go(1'b0);
		$display("test tx done");
		for (int k = 0; k < 2; k++) begin
			for (int i = 1; i <= 3; i++)
				b[i] = 8'($random(seed));
			c = crc(b) ^ 16'(k);
			b[4] = c[7:0];
			b[5] = c[15:8];
			e = 8'($random(seed));
			wr(`RAMS_ADDR_SEQ, 16'h0102);
			i_rams_host_model.go(1'b1);
			cyc(6);
			energyLevel <= e;
			@(posedge clk_sys);
			preambleSeen <= 1'b1;
			// second pass: delimiter together with preamble
			sfdSeen <= 1'(k);
			@(posedge clk_sys);
			preambleSeen <= 1'b0;
			sfdSeen <= 1'b1;
			@(posedge clk_sys);
			sfdSeen <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				rxByte <= b[i];
				rxByteValid <= 1'b1;
				@(posedge clk_sys);
				rxByteValid <= 1'b0;
				@(posedge clk_sys);
			end
			wait_irq();
			chk("rx irq", 16'h0000, {14'h0000, rxPowerOn, irqB});
			cyc(2600);
			rdw(`RAMS_ADDR_RX_INFO, 1);
			chk("len quality", {e, 8'h05}, rd[0]);
			rdw(`RAMS_ADDR_STATUS, 1);
			chk("rx flags", 16'h0080 | 16'(k == 0), rd[0] & 16'h00C1);
			chk("irq clr", 16'h0001, {15'h0000, irqB});
			rdw(`RAMS_ADDR_RX_WIN, 2);
			chk("rx ram", {b[2], b[1]}, rd[0]);
			chk("rx ram", {b[4], b[3]}, rd[1]);
			i_rams_host_model.go(1'b0);
		end
		$display("test rx done");
		for (int m = 0; m < 2; m++) begin
			wr(`RAMS_ADDR_SEQ, 16'h0102);
			i_rams_host_model.go(1'b1);
			cyc(8);
			@(posedge clk_sys);
			preambleSeen <= 1'b1;
			@(posedge clk_sys);
			preambleSeen <= 1'b0;
			if (m)
				wr(`RAMS_ADDR_SEQ, 16'h0000);
			i_rams_host_model.go(1'b0);
			cyc(8);
			chk("abort", 16'h0001, {14'h0000, rxPowerOn, irqB});
			rdw(`RAMS_ADDR_STATUS, 1);
			chk("abort flags", 16'h0000, rd[0] & 16'h00C0);
		end
		$display("test abort done");
		print_verdict();
	end
endmodule
